// ==== rtl/ccp_unit.sv ====
/*
 * Two capture/compare/PWM units behind an APB slave.
 * Assumes timers, period registers and trigger sources outside,
 * all synchronous to clk; pin inputs are already synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ccp_map.svh"

//Contract
// - Sleep freezes unit, holds pin, keeps timer
// - PWM timing follows the system clock
// - Reset makes pins inputs, registers reset except value
// - Control bit 7 enables unit, resets 0
// - Control bit 5 read-only output level
// - Bit 4 picks duty alignment in PWM
// - Mode 11xx PWM, 0000 off, events flag
// - Capture edge modes 0011 to 0111
// - Set/clear output latched until mode off
// - Pulse modes 1010/1011, toggle 0010/0001
// - Modes 0001/1011 clear associated timer
// - Trigger field selects capture source
// - Capture/compare value uses full 16 bits
// - Right aligned duty in bits 9:0
// - Left aligned duty in bits 15:6
// - Value register survives reset
// - Independent timer selection per unit
// - Timer field 01 first, 10 second pair
// - Period match reloads duty, sets output unless duty zero
// - Time base match with duty clears output
module ccp_unit #(
    parameter int ADDR_W = 16
) (
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  sleep,
    input  wire ccp_pkg::ccp_timer_t   timer_a,
    input  wire ccp_pkg::ccp_timer_t   timer_b,
    input  wire ccp_pkg::ccp_trig_t    trig,
    input  wire logic [1:0]            pin_in,
    output logic      [1:0]            unit_pin,
    output logic      [1:0]            unit_pin_oe,
    output logic      [1:0]            unit_interrupt_flag,
    output logic      [1:0]            wide_timer_clear
);

    // ************************************************************
    // Register decode
    // ************************************************************

    localparam logic [13:0] IDX_VAL [2] = '{`CCP_IDX_VAL1, `CCP_IDX_VAL2};
    localparam logic [13:0] IDX_CON [2] = '{`CCP_IDX_CON1, `CCP_IDX_CON2};
    localparam logic [13:0] IDX_CAP [2] = '{`CCP_IDX_CAP1, `CCP_IDX_CAP2};

    // True for the PWM mode codes.
    function automatic logic ccp_is_pwm(input logic [3:0] mode);
        ccp_is_pwm = (mode[3:2] == `CCP_PWM_TOP);
    endfunction : ccp_is_pwm

    // True for the compare mode codes.
    function automatic logic ccp_is_cmp(input logic [3:0] mode);
        ccp_is_cmp = (mode == `CCP_MODE_TGLC) || (mode == `CCP_MODE_TGL)
                  || (mode[3:2] == 2'h2);
    endfunction : ccp_is_cmp

    logic [13:0] idx;
    logic        acc;
    logic        wr;
    logic [7:0]  tmrs;
    logic [15:0] val_w [2];
    logic [7:0]  con_w [2];
    logic [3:0]  cap_w [2];
    logic        hit_val [2];
    logic        hit_con [2];
    logic        hit_cap [2];
    logic        hit_tmrs;
    logic        mapped;
    logic [31:0] rd_mux;

    // Access phase and the write strobe at the completing edge.
    assign idx      = paddr[15:2];
    assign acc      = psel && penable;
    assign wr       = acc && pready && pwrite;
    assign hit_tmrs = (idx == `CCP_IDX_TMRS);
    assign hit_val[0] = (idx == IDX_VAL[0]);
    assign hit_val[1] = (idx == IDX_VAL[1]);
    assign hit_con[0] = (idx == IDX_CON[0]);
    assign hit_con[1] = (idx == IDX_CON[1]);
    assign hit_cap[0] = (idx == IDX_CAP[0]);
    assign hit_cap[1] = (idx == IDX_CAP[1]);
    assign mapped = hit_tmrs || hit_val[0] || hit_val[1] || hit_con[0]
                 || hit_con[1] || hit_cap[0] || hit_cap[1];

    // Read data selection; unmapped words read zero.
    assign rd_mux = hit_val[0] ? {16'h0000, val_w[0]} :
                    hit_val[1] ? {16'h0000, val_w[1]} :
                    hit_con[0] ? {24'h00_0000, con_w[0]} :
                    hit_con[1] ? {24'h00_0000, con_w[1]} :
                    hit_cap[0] ? {28'h000_0000, cap_w[0]} :
                    hit_cap[1] ? {28'h000_0000, cap_w[1]} :
                    hit_tmrs   ? {24'h00_0000, tmrs} : 32'h0000_0000;

    // ************************************************************
    // APB slave: one wait state, registered answer
    // ************************************************************

    // Answer one cycle into the access phase.
    always_ff @(posedge clk) begin
        if (srst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc && !pready;
            prdata  <= rd_mux;
            pslverr <= acc && !pready && !mapped;
        end
    end

    // Timer pairing field of both units.
    always_ff @(posedge clk) begin
        if (srst) begin
            tmrs <= `CCP_TMRS_RST;
        end else if (wr && hit_tmrs && mapped) begin
            tmrs <= {4'h0, pwdata[3:0]};
        end
    end

    // ************************************************************
    // Unit instances
    // ************************************************************

    for (genvar i = 0; i < 2; i++) begin : g_unit
        ccp_pkg::ccp_ctrl_t  ctrl;
        ccp_pkg::ccp_timer_t tm;
        logic [15:0] value_q;
        logic [3:0]  cts;
        logic [9:0]  duty;
        logic [9:0]  duty_buf;
        logic [9:0]  tbase;
        logic [3:0]  pre;
        logic        src;
        logic        src_d;
        logic        rise;
        logic        fall;
        logic        cap_evt;
        logic        match;
        logic        match_d;
        logic        cmp_hit;
        logic        out_q;
        logic        oe_q;
        logic        irq_q;
        logic        clr_q;
        logic        wr_val;
        logic        wr_con;
        logic        is_pwm;
        logic        is_cap;
        logic        per_hit;
        logic        off_req;

        // Timer pair chosen by this unit's own field.
        assign tm = (tmrs[2*i+:2] == `CCP_TSEL_2ND) ? timer_b : timer_a;

        // Capture trigger source selection; reserved codes never fire.
        assign src = (cts == `CCP_CTS_PIN)  ? pin_in[i]   :
                     (cts == `CCP_CTS_CMP1) ? trig.cmp[0] :
                     (cts == `CCP_CTS_CMP2) ? trig.cmp[1] :
                     (cts == `CCP_CTS_IOC)  ? trig.pin_change_event    :
                     (cts == `CCP_CTS_CLC1) ? trig.clc[0] :
                     (cts == `CCP_CTS_CLC2) ? trig.clc[1] :
                     (cts == `CCP_CTS_CLC3) ? trig.clc[2] :
                     (cts == `CCP_CTS_CLC4) ? trig.clc[3] : 1'b0;

        // Mode decode and event detection.
        assign is_pwm = ccp_is_pwm(ctrl.mode);
        assign is_cap = !is_pwm && !ccp_is_cmp(ctrl.mode)
                     && (ctrl.mode != `CCP_MODE_OFF);
        assign rise = src && !src_d;
        assign fall = !src && src_d;
        assign cap_evt = ctrl.en && is_cap && (
            ((ctrl.mode == `CCP_MODE_CEDGE) && (rise || fall)) ||
            ((ctrl.mode == `CCP_MODE_CFALL) && fall) ||
            ((ctrl.mode == `CCP_MODE_CRISE) && rise) ||
            ((ctrl.mode == `CCP_MODE_CR4) && rise && (pre[1:0] == `CCP_PRE_R4)) ||
            ((ctrl.mode == `CCP_MODE_CR16) && rise && (pre == `CCP_PRE_R16)));
        assign match   = (tm.wide == value_q);
        assign cmp_hit = ctrl.en && ccp_is_cmp(ctrl.mode) && match && !match_d;

        // Duty alignment; the bit is ignored outside PWM.
        assign duty = ctrl.fmt ? {value_q[15:8], value_q[7:6]}
                               : value_q[9:0];
        assign tbase   = {tm.pwm, tm.low};
        assign per_hit = tm.tick && (tm.pwm == tm.per);

        // Bus strobes and the release of a latched compare result.
        assign wr_val  = wr && hit_val[i];
        assign wr_con  = wr && hit_con[i];
        assign off_req = wr_con && (!pwdata[7] || (pwdata[3:0] == `CCP_MODE_OFF));

        // Control and trigger select; output level bit is not writable.
        always_ff @(posedge clk) begin
            if (srst) begin
                ctrl <= '{en: 1'b0, fmt: 1'b0, mode: `CCP_MODE_RST};
                cts  <= `CCP_CAP_RST;
            end else begin
                if (wr_con) begin
                    ctrl <= '{en: pwdata[7], fmt: pwdata[4], mode: pwdata[3:0]};
                end
                if (wr && hit_cap[i]) begin
                    cts <= pwdata[3:0];
                end
            end
        end

        // Value register: no reset; a capture wins over a bus write.
        always_ff @(posedge clk) begin
            if (!sleep && cap_evt) begin
                value_q <= tm.wide;
            end else if (wr_val) begin
                value_q <= pwdata[15:0];
            end
        end

        // Capture, compare and PWM engine, frozen in sleep.
        always_ff @(posedge clk) begin
            if (srst) begin
                src_d    <= 1'b0;
                match_d  <= 1'b0;
                pre      <= 4'h0;
                out_q    <= 1'b0;
                oe_q     <= 1'b0;
                irq_q    <= 1'b0;
                clr_q    <= 1'b0;
                duty_buf <= `CCP_DUTY_ZERO;
            end else if (sleep) begin
                irq_q <= 1'b0;
                clr_q <= 1'b0;
            end else begin
                src_d   <= src;
                match_d <= match;
                oe_q    <= ctrl.en && (is_pwm || ccp_is_cmp(ctrl.mode));
                irq_q   <= cap_evt || cmp_hit || (ctrl.en && is_pwm && per_hit);
                clr_q   <= cmp_hit && ((ctrl.mode == `CCP_MODE_TGLC)
                                    || (ctrl.mode == `CCP_MODE_PLSC));
                if (!ctrl.en || !is_cap) begin
                    pre <= 4'h0;
                end else if (rise) begin
                    pre <= pre + 4'h1;
                end
                if (off_req || !ctrl.en || (ctrl.mode == `CCP_MODE_OFF)) begin
                    out_q <= 1'b0;
                end else if (is_pwm) begin
                    if (per_hit) begin
                        duty_buf <= duty;
                        out_q    <= (duty != `CCP_DUTY_ZERO);
                    end else if (tbase == duty_buf) begin
                        out_q <= 1'b0;
                    end
                end else if (cmp_hit) begin
                    unique case (ctrl.mode)
                        `CCP_MODE_SET:  out_q <= 1'b1;
                        `CCP_MODE_CLR:  out_q <= 1'b0;
                        `CCP_MODE_PLS,
                        `CCP_MODE_PLSC: out_q <= 1'b1;
                        default:        out_q <= !out_q;
                    endcase
                end else if ((ctrl.mode == `CCP_MODE_PLS)
                          || (ctrl.mode == `CCP_MODE_PLSC)) begin
                    out_q <= 1'b0;
                end
            end
        end

        // Register read views and pin outputs.
        assign val_w[i] = value_q;
        assign con_w[i] = {ctrl.en, 1'b0, out_q, ctrl.fmt, ctrl.mode};
        assign cap_w[i] = cts;
        assign unit_pin[i]            = out_q;
        assign unit_pin_oe[i]         = oe_q;
        assign unit_interrupt_flag[i] = irq_q;
        assign wide_timer_clear[i]    = clr_q;
    end

endmodule : ccp_unit
`default_nettype wire

// ==== rtl/ccp_map.svh ====
/*
 * Register indices, reset values and codes of the
 * capture/compare/PWM unit.
 * Assumes inclusion by bare name from the unit and the bench.
 */
`ifndef CCP_MAP_SVH
`define CCP_MAP_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define CCP_IDX_VAL1   14'h040c
`define CCP_IDX_CON1   14'h040e
`define CCP_IDX_CAP1   14'h040f
`define CCP_IDX_VAL2   14'h0410
`define CCP_IDX_CON2   14'h0412
`define CCP_IDX_CAP2   14'h0413
`define CCP_IDX_TMRS   14'h041f

// ************************************************************
// Reset values
// ************************************************************
`define CCP_TMRS_RST   8'h05
`define CCP_CAP_RST    4'h0
`define CCP_MODE_RST   4'h0

// ************************************************************
// Mode codes
// ************************************************************
`define CCP_MODE_OFF   4'h0
`define CCP_MODE_TGLC  4'h1
`define CCP_MODE_TGL   4'h2
`define CCP_MODE_CEDGE 4'h3
`define CCP_MODE_CFALL 4'h4
`define CCP_MODE_CRISE 4'h5
`define CCP_MODE_CR4   4'h6
`define CCP_MODE_CR16  4'h7
`define CCP_MODE_SET   4'h8
`define CCP_MODE_CLR   4'h9
`define CCP_MODE_PLS   4'ha
`define CCP_MODE_PLSC  4'hb
`define CCP_PWM_TOP    2'h3

// ************************************************************
// Trigger source codes, timer pair codes, prescaler counts and zero duty
// ************************************************************
`define CCP_CTS_PIN    4'h0
`define CCP_CTS_CMP1   4'h1
`define CCP_CTS_CMP2   4'h2
`define CCP_CTS_IOC    4'h3
`define CCP_CTS_CLC1   4'h4
`define CCP_CTS_CLC2   4'h5
`define CCP_CTS_CLC3   4'h6
`define CCP_CTS_CLC4   4'h7
`define CCP_TSEL_2ND   2'h2
`define CCP_PRE_R4     2'h3
`define CCP_PRE_R16    4'hf
`define CCP_DUTY_ZERO  10'h000

`endif

// ==== rtl/ccp_pkg.sv ====
/*
 * Types shared by the capture/compare/PWM unit.
 * Assumes nothing of its surroundings.
 */
package ccp_pkg;

    // Control fields of one unit.
    typedef struct packed {
        logic       en;
        logic       fmt;
        logic [3:0] mode;
    } ccp_ctrl_t;

    // One timer pair as seen by one unit.
    typedef struct packed {
        logic [15:0] wide;
        logic [7:0]  pwm;
        logic [1:0]  low;
        logic [7:0]  per;
        logic        tick;
    } ccp_timer_t;

    // Internal capture trigger sources.
    typedef struct packed {
        logic [1:0] cmp;
        logic       pin_change_event;
        logic [3:0] clc;
    } ccp_trig_t;

endpackage : ccp_pkg

// ==== verif/ccp_far_side.sv ====
/* Far-side model: the two timer pairs that feed the unit.
   Assumes clk and srst of the unit; unit 1 clear goes to pair a. */
`timescale 1ns/1ps
`default_nettype none
module ccp_far_side #(
    parameter logic [7:0] PER = 8'h03
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                sleep,
    input  wire logic [1:0]          clr,
    output ccp_pkg::ccp_timer_t      timer_a,
    output ccp_pkg::ccp_timer_t      timer_b
);
    // ************************************************************
    // Timers
    // ************************************************************
    logic [15:0] wa, wb;
    logic [7:0]  pc;
    // Timers freeze in sleep and resume from where they stood.
    always_ff @(posedge clk) begin
        if (srst) begin
            wa <= 16'h0000;
            wb <= 16'h8000;
            pc <= 8'h00;
        end else if (!sleep) begin
            wa <= clr[0] ? 16'h0000 : wa + 16'h0001;
            wb <= clr[1] ? 16'h0000 : wb + 16'h0001;
            pc <= (pc == PER) ? 8'h00 : pc + 8'h01;
        end
    end
    // The pwm timer ticks on every system clock outside sleep.
    assign timer_a = '{wide: wa, pwm: pc, low: 2'h0, per: PER, tick: !sleep};
    assign timer_b = '{wide: wb, pwm: pc, low: 2'h0, per: PER, tick: !sleep};
endmodule : ccp_far_side
`default_nettype wire

// ==== verif/ccp_unit_checker.sv ====
/* Port-level properties of ccp_unit.
   Assumes the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module ccp_unit_checker (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       sleep,
    input wire logic [1:0] unit_pin,
    input wire logic [1:0] unit_pin_oe,
    input wire logic [1:0] unit_interrupt_flag,
    input wire logic [1:0] wide_timer_clear
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // A setup cycle followed by the first access cycle.
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    a_ready_time: assert property (s_access |=> pready)
        else $error("Bus answer not in the second access cycle.");
    a_ready_once: assert property (pready |=> !pready)
        else $error("Ready held longer than one cycle.");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("Error flag without ready.");
    a_reset_quiet: assert property (disable iff (1'b0) srst |=>
        (unit_pin_oe == 2'h0) && (unit_pin == 2'h0) && (unit_interrupt_flag == 2'h0))
        else $error("Outputs not quiet after reset.");
    a_sleep_hold: assert property ($past(sleep) && !$past(srst) |->
        $stable(unit_pin) && $stable(unit_pin_oe))
        else $error("Pin moved during sleep.");
    a_sleep_noflag: assert property ($past(sleep) |-> unit_interrupt_flag == 2'h0)
        else $error("Event flagged during sleep.");
    a_flag_pulse: assert property (
        (unit_interrupt_flag & $past(unit_interrupt_flag)) == 2'h0)
        else $error("Flag longer than one cycle.");
    a_clear_flag: assert property ((wide_timer_clear & ~unit_interrupt_flag) == 2'h0)
        else $error("Timer clear without its match flag.");
    a_clear_once: assert property (
        (wide_timer_clear & $past(wide_timer_clear)) == 2'h0)
        else $error("Timer clear longer than one cycle.");
endmodule : ccp_unit_checker
bind ccp_unit ccp_unit_checker u_chk (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .sleep(sleep),
    .unit_pin(unit_pin), .unit_pin_oe(unit_pin_oe),
    .unit_interrupt_flag(unit_interrupt_flag), .wide_timer_clear(wide_timer_clear));
`default_nettype wire

// ==== verif/tb_top.sv ====
/* Self-checking bench of ccp_unit over APB.
   Assumes the far-side model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "ccp_map.svh"
module tb_top;
    // ************************************************************
    // Design, far side and counters
    // ************************************************************
    logic                clk, srst, psel, penable, pwrite, sleep, pready, pslverr, err;
    logic [15:0]         paddr;
    logic [31:0]         pwdata, prdata, rd, ex;
    logic [1:0]          pin_in, unit_pin, oe, flag, clr;
    ccp_pkg::ccp_trig_t  trig;
    ccp_pkg::ccp_timer_t ta, tb2;
    int                  bad_count, total_checks, nflag, nhi, i, n0, h0;
    // Control, value, relative, pulses, sleep, flag range, high-cycle range.
    int tbl [17][9] = '{'{8'h85,0,0,2,0,2,2,0,99}, '{8'h83,0,0,2,0,4,4,0,99},
        '{8'h84,0,0,2,0,2,2,0,99}, '{8'h86,0,0,3,0,0,0,0,99},
        '{8'h86,0,0,4,0,1,1,0,99}, '{8'h87,0,0,16,0,1,1,0,99},
        '{8'h85,0,0,2,1,0,0,0,99}, '{8'h89,30,1,0,0,1,1,0,0},
        '{8'h8a,30,1,0,0,1,1,1,1}, '{8'h82,30,1,0,0,1,1,1,60},
        '{8'h81,30,1,0,0,1,1,1,60}, '{8'h8b,30,1,0,0,1,1,1,1},
        '{8'h8c,8,0,0,0,14,16,28,46}, '{8'h9c,16'h0200,0,0,0,14,16,28,46},
        '{8'h8c,0,0,0,0,14,16,0,4}, '{8'h9c,8,0,0,0,14,16,0,4},
        '{8'h88,30,1,0,0,1,1,1,60}};
    ccp_unit dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep(sleep), .timer_a(ta),
        .timer_b(tb2), .trig(trig), .pin_in(pin_in), .unit_pin(unit_pin),
        .unit_pin_oe(oe), .unit_interrupt_flag(flag), .wide_timer_clear(clr));
    ccp_far_side far (.clk(clk), .srst(srst), .sleep(sleep), .clr(clr),
        .timer_a(ta), .timer_b(tb2));
    // Clock, and counts of flags and high pin cycles of either unit.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if ((|flag) === 1'b1) nflag++;
        if ((|unit_pin) === 1'b1) nhi++;
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task chk(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
        total_checks++;
        if (((g >= lo) && (g <= hi)) !== 1'b1) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
        end
    endtask : chk
    task apb(input logic w, input logic [13:0] x, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {x, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task pulse(input logic [7:0] m, input int n);
        repeat (n) begin
            @(posedge clk);
            trig <= m[6:0];
            pin_in[0] <= m[7];
            repeat (2) @(posedge clk);
            trig <= 7'h00;
            pin_in[0] <= 1'b0;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
    endtask : pulse
    task run(input int k);
        int   t[9];
        logic drv;
        t = tbl[k];
        drv = !((t[0] % 16) inside {[3:7]});
        apb(1'b1, `CCP_IDX_VAL1, t[1] + (t[2] != 0 ? ta.wide : 16'h0000));
        apb(1'b1, `CCP_IDX_CON1, 32'h0000_0000);
        apb(1'b1, `CCP_IDX_CON1, t[0]);
        sleep <= (t[4] != 0);
        nflag = 0;
        nhi = 0;
        if (t[3] != 0) pulse(8'h80, t[3]);
        else repeat (60) @(posedge clk);
        sleep <= 1'b0;
        chk(nflag, t[5], t[6]);
        chk(nhi, t[7], t[8]);
        chk(oe[0], drv, drv);
        if (t[0] == 8'h8b) chk(ta.wide, 0, 63);
        $display("mode test %0d done", k);
    endtask : run
    task stop_test;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        {psel, penable, pwrite, sleep, srst} = 5'b00001;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        pin_in = 2'b00;
        trig = 7'h00;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        apb(1'b1, `CCP_IDX_CON1, 32'h0000_0020);
        apb(1'b0, `CCP_IDX_CON1, 32'h0000_0000);
        chk(rd, 0, 0);
        apb(1'b0, `CCP_IDX_CAP2, 32'h0000_0000);
        chk(rd, 0, 0);
        chk(oe, 0, 0);
        apb(1'b0, 14'h0001, 32'h0000_0000);
        chk(err, 1, 1);
        chk(rd, 0, 0);
        apb(1'b1, `CCP_IDX_TMRS, 32'h0000_000a);
        apb(1'b0, `CCP_IDX_TMRS, 32'h0000_0000);
        chk(rd, 8'h0a, 8'h0a);
        apb(1'b1, `CCP_IDX_VAL1, 32'h0000_a5c3);
        @(posedge clk) srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        apb(1'b0, `CCP_IDX_VAL1, 32'h0000_0000);
        chk(rd, 16'ha5c3, 16'ha5c3);
        apb(1'b0, `CCP_IDX_TMRS, 32'h0000_0000);
        chk(rd, 8'h05, 8'h05);
        $display("register test done");
        apb(1'b1, `CCP_IDX_TMRS, 32'h0000_0006);
        apb(1'b1, `CCP_IDX_CON1, 32'h0000_0085);
        @(posedge clk) pin_in[0] <= 1'b1;
        #1 ex = tb2.wide;
        @(posedge clk) pin_in[0] <= 1'b0;
        #1 chk(flag[0], 1, 1);
        apb(1'b0, `CCP_IDX_VAL1, 32'h0000_0000);
        chk(rd, ex, ex);
        apb(1'b1, `CCP_IDX_TMRS, 32'h0000_0005);
        for (i = 1; i < 9; i++) begin
            apb(1'b1, `CCP_IDX_CAP1, i);
            n0 = nflag;
            pulse(i == 8 ? 8'hff : (i < 3 ? 8'h10 << i : (i == 3 ? 8'h10 : 8'h01 << (i - 4))), 1);
            chk(nflag - n0, i < 8, i < 8);
        end
        apb(1'b1, `CCP_IDX_CAP1, 32'h0000_0000);
        $display("capture test done");
        for (i = 0; i < 17; i++) run(i);
        apb(1'b0, `CCP_IDX_CON1, 32'h0000_0000);
        chk(rd, 8'ha8, 8'ha8);
        // Unit two on the second pair: pulse and clear of its own timer.
        apb(1'b1, `CCP_IDX_CON1, 32'h0000_0000);
        apb(1'b1, `CCP_IDX_TMRS, 32'h0000_0009);
        apb(1'b1, `CCP_IDX_VAL2, 32'h0000_0014 + tb2.wide);
        apb(1'b1, `CCP_IDX_CON2, 32'h0000_008b);
        n0 = nflag;
        h0 = nhi;
        repeat (40) @(posedge clk);
        chk(nflag - n0, 1, 1);
        chk(nhi - h0, 1, 1);
        chk(oe, 2'h2, 2'h2);
        chk(tb2.wide, 0, 39);
        $display("unit two test done");
        stop_test;
    end
    // Cuts a hang short well past the expected run length.
    initial begin
        #400us;
        bad_count++;
        stop_test;
    end
endmodule : tb_top
`default_nettype wire
